// >>> hdl/mpcs_command_core.v
// Parameter store, diagnostics and command sequencing of the modem
// Notes on behaviour
// - Line seven setting 0..5 except 2; default 1 (flow control).
// - Input eight accepts only 0 or 3; default 0.
// - On an end device, force-disassociate drops association, then starts a new attempt.
// - Signal strength is read-only magnitude, 0 to 0x64.
// - Signal strength reads zero after reset or sleep until a packet.
// - Destination is 64 bits from two 32-bit halves, both default zero.
// - Data exchanged only when channel, network id and destination match.
// - Short addressing when upper zero and lower below 0xFFFF; 0xFFFF broadcast.
// - Name lookup success loads destination, replies OK, leaves command mode.
// - Lookup times out after 200 ms or blank name, replying ERROR.
// - Unassociated cyclic sleeper sleeps period x 10 ms; 1..0x68B0, default 0x3E8.
// - Ack-failure counter saturates at 0xFFFF, cleared by writing zero.
// - Channel-assessment failure counter saturates, cleared by writing zero.
// - Energy scan dwells 2^arg x 15.36 ms per channel, peak value per channel, one CR at end.
// - With encryption on, the 64-bit long address is the source.
// - With encryption on, packets limited to 95 bytes; one shared key.
// - With encryption on, unencrypted received packets are discarded.
// - Framed host mode marks each receive frame with an encrypted flag.
// - MAC mode, framed mode, encryption and short address give 64-bit indications.
// - Force-poll requests held indirect messages from the coordinator.
// - Software reset acts as a power cycle.
`timescale 1ns/1ps
`include "mpcs_map.vh"
module mpcs_command_core #(
  parameter LOOKUP_CYCLES = (`MPCS_LOOKUP_TIMEOUT_US * 1000) / `MPCS_CLK_NS,
  parameter SCAN_BASE_CYCLES = `MPCS_SCAN_BASE_NS / `MPCS_CLK_NS,
  parameter SLEEP_UNIT_CYCLES = `MPCS_SLEEP_UNIT_NS / `MPCS_CLK_NS,
  parameter SCAN_CHANNELS = 16
) (
  input wire clk,
  input wire rst_b,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [31:0] cmd_arg,
  input wire [4:0] name_len,
  output reg reply_ok,
  output reg reply_error,
  output reg exit_command_mode,
  output reg [2:0] line7_config,
  output reg [2:0] input8_config,
  output reg [31:0] dest_addr_upper,
  output reg [31:0] dest_addr_lower,
  output reg [15:0] unassoc_sleep_period,
  output reg encrypt_enable,
  output wire [15:0] ack_fail_counter,
  output wire [15:0] cca_fail_counter,
  output reg [6:0] rx_strength_read,
  input wire end_device,
  input wire cyclic_sleep_mode,
  input wire associated,
  input wire assoc_failed,
  output reg drop_association,
  output reg start_association,
  output reg poll_request,
  output wire unassoc_sleeping,
  input wire name_match_valid,
  input wire [63:0] name_match_addr,
  input wire rx_packet,
  input wire [6:0] rx_strength,
  input wire rx_encrypted,
  input wire sleep_event,
  output reg rx_forward,
  output reg rx_option_encrypted,
  output reg rx_long_indication,
  input wire [7:0] channel_number,
  input wire [15:0] network_identifier,
  input wire [7:0] peer_channel,
  input wire [15:0] peer_network,
  input wire [63:0] peer_dest,
  output wire peer_match,
  input wire framed_host_mode,
  input wire [1:0] mac_mode_setting,
  input wire [15:0] source_short_addr,
  output wire tx_short_addressing,
  output wire tx_broadcast,
  output wire tx_source_long,
  output wire [6:0] tx_max_packet,
  input wire ack_retries_out,
  input wire cca_withheld,
  input wire [7:0] scan_energy,
  output reg scan_active,
  output reg [4:0] scan_channel,
  output reg [7:0] scan_out_data,
  output reg scan_out_valid,
  output reg scan_out_is_cr,
  output reg soft_reset_pulse
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LOOKUP = 2'h1;
  localparam ST_SCAN = 2'h2;
  localparam ST_SCAN_CR = 2'h3;
  localparam [33:0] SLEEP_UNIT_W = SLEEP_UNIT_CYCLES;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] scan_arg;
  reg [7:0] scan_peak;
  reg sw_reset_req;
  reg sw_reset_hold;
  wire core_rst_b;
  wire cmd_take;
  wire ack_clear;
  wire cca_clear;
  wire lookup_done;
  wire dwell_busy;
  wire dwell_done;
  wire sleep_done;
  wire [31:0] dwell_load;
  wire [33:0] sleep_load;
  wire cmd_range_ok;
  wire short_addr_set;
  // Software reset folds into the core reset for one cycle
  assign core_rst_b = rst_b & ~sw_reset_hold;
  assign cmd_take = cmd_valid && state == ST_IDLE;
  assign ack_clear = cmd_take && cmd_code == `MPCS_CMD_WR_ACK_CNT && cmd_arg == 32'h0;
  assign cca_clear = cmd_take && cmd_code == `MPCS_CMD_WR_CCA_CNT && cmd_arg == 32'h0;
  assign dwell_load = SCAN_BASE_CYCLES << scan_arg;
  assign sleep_load = {18'h0, unassoc_sleep_period} * SLEEP_UNIT_W;
  // Range check per command
  assign cmd_range_ok =
    (cmd_code == `MPCS_CMD_WR_LINE7) ? (cmd_arg <= 32'h5 && cmd_arg != 32'h2) :
    (cmd_code == `MPCS_CMD_WR_INPUT8) ? (cmd_arg == 32'h0 || cmd_arg == 32'h3) :
    (cmd_code == `MPCS_CMD_WR_SLEEP_PER) ?
      (cmd_arg >= 32'h1 && cmd_arg <= {16'h0, `MPCS_SLEEP_PER_MAX}) :
    (cmd_code == `MPCS_CMD_WR_ACK_CNT || cmd_code == `MPCS_CMD_WR_CCA_CNT) ?
      (cmd_arg == 32'h0) :
    (cmd_code == `MPCS_CMD_ENERGY_SCAN) ? (cmd_arg <= {29'h0, `MPCS_SCAN_ARG_MAX}) :
    (cmd_code == `MPCS_CMD_WR_ENCRYPT) ? (cmd_arg <= 32'h1) :
    (cmd_code == `MPCS_CMD_NAME_LOOKUP) ?
      (name_len != 5'h0 && name_len <= `MPCS_NAME_MAX) :
    (cmd_code == `MPCS_CMD_NONE) ? 1'b0 :
    (cmd_code > `MPCS_CMD_SOFT_RESET) ? 1'b0 : 1'b1;
  // Addressing decisions
  assign tx_short_addressing = dest_addr_upper == 32'h0 &&
    dest_addr_lower < `MPCS_SHORT_LIMIT;
  assign tx_broadcast = dest_addr_upper == 32'h0 &&
    dest_addr_lower == `MPCS_SHORT_LIMIT;
  assign peer_match = peer_channel == channel_number &&
    peer_network == network_identifier &&
    peer_dest == {dest_addr_upper, dest_addr_lower};
  assign tx_source_long = encrypt_enable;
  assign tx_max_packet = encrypt_enable ? `MPCS_ENC_PKT_MAX : 7'h7F;
  assign short_addr_set = source_short_addr < 16'hFFFE;
  mpcs_sat_counter #(.WIDTH(16)) u_ack_cnt (
    .clk(clk),
    .rst_b(core_rst_b),
    .event_in(ack_retries_out),
    .clear(ack_clear),
    .count(ack_fail_counter)
  );
  mpcs_sat_counter #(.WIDTH(16)) u_cca_cnt (
    .clk(clk),
    .rst_b(core_rst_b),
    .event_in(cca_withheld),
    .clear(cca_clear),
    .count(cca_fail_counter)
  );
  mpcs_timer #(.WIDTH(32)) u_lookup_tmr (
    .clk(clk),
    .rst_b(core_rst_b),
    .load(cmd_take && cmd_code == `MPCS_CMD_NAME_LOOKUP && cmd_range_ok),
    .load_value(LOOKUP_CYCLES),
    .cancel(state == ST_LOOKUP && name_match_valid),
    .busy(),
    .done(lookup_done)
  );
  mpcs_timer #(.WIDTH(32)) u_dwell_tmr (
    .clk(clk),
    .rst_b(core_rst_b),
    .load((cmd_take && cmd_code == `MPCS_CMD_ENERGY_SCAN && cmd_range_ok) ||
      (state == ST_SCAN && dwell_done && scan_channel != SCAN_CHANNELS - 1)),
    .load_value((cmd_take ? (SCAN_BASE_CYCLES << cmd_arg[2:0]) : dwell_load) - 32'h1),
    .cancel(1'b0),
    .busy(dwell_busy),
    .done(dwell_done)
  );
  mpcs_timer #(.WIDTH(34)) u_sleep_tmr (
    .clk(clk),
    .rst_b(core_rst_b),
    .load(end_device && cyclic_sleep_mode && assoc_failed && !unassoc_sleeping),
    .load_value(sleep_load),
    .cancel(1'b0),
    .busy(unassoc_sleeping),
    .done(sleep_done)
  );
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_take && cmd_range_ok && cmd_code == `MPCS_CMD_NAME_LOOKUP) begin
          next_state = ST_LOOKUP;
        end else if (cmd_take && cmd_range_ok && cmd_code == `MPCS_CMD_ENERGY_SCAN) begin
          next_state = ST_SCAN;
        end
      end
      ST_LOOKUP: begin
        if (name_match_valid || lookup_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_SCAN: begin
        if (dwell_done && scan_channel == SCAN_CHANNELS - 1) begin
          next_state = ST_SCAN_CR;
        end
      end
      ST_SCAN_CR: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  // Software reset request captured, applied the next cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_reset_req <= 1'b0;
      sw_reset_hold <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      sw_reset_req <= cmd_take && cmd_code == `MPCS_CMD_SOFT_RESET && !sw_reset_req;
      sw_reset_hold <= sw_reset_req;
      soft_reset_pulse <= sw_reset_req;
    end
  end

  always @(posedge clk or negedge core_rst_b) begin
    if (!core_rst_b) begin
      state <= ST_IDLE;
      reply_ok <= 1'b0;
      reply_error <= 1'b0;
      exit_command_mode <= 1'b0;
      line7_config <= `MPCS_LINE7_RESET;
      input8_config <= `MPCS_INPUT8_RESET;
      dest_addr_upper <= 32'h0;
      dest_addr_lower <= 32'h0;
      unassoc_sleep_period <= `MPCS_SLEEP_PER_RESET;
      encrypt_enable <= 1'b0;
      rx_strength_read <= 7'h0;
      drop_association <= 1'b0;
      start_association <= 1'b0;
      poll_request <= 1'b0;
      rx_forward <= 1'b0;
      rx_option_encrypted <= 1'b0;
      rx_long_indication <= 1'b0;
      scan_active <= 1'b0;
      scan_channel <= 5'h0;
      scan_arg <= 3'h0;
      scan_peak <= 8'h0;
      scan_out_data <= 8'h0;
      scan_out_valid <= 1'b0;
      scan_out_is_cr <= 1'b0;
    end else begin
      state <= next_state;
      reply_ok <= 1'b0;
      reply_error <= 1'b0;
      exit_command_mode <= 1'b0;
      drop_association <= 1'b0;
      start_association <= drop_association;
      poll_request <= 1'b0;
      rx_forward <= 1'b0;
      scan_out_valid <= 1'b0;
      scan_out_is_cr <= 1'b0;
      if (cmd_take) begin
        if (!cmd_range_ok) begin
          reply_error <= 1'b1;
        end else begin
          case (cmd_code)
            `MPCS_CMD_WR_LINE7: line7_config <= cmd_arg[2:0];
            `MPCS_CMD_WR_INPUT8: input8_config <= cmd_arg[2:0];
            `MPCS_CMD_DISASSOC: drop_association <= end_device;
            `MPCS_CMD_WR_DEST_HI: dest_addr_upper <= cmd_arg;
            `MPCS_CMD_WR_DEST_LO: dest_addr_lower <= cmd_arg;
            `MPCS_CMD_WR_SLEEP_PER: unassoc_sleep_period <= cmd_arg[15:0];
            `MPCS_CMD_WR_ENCRYPT: encrypt_enable <= cmd_arg[0];
            `MPCS_CMD_POLL: poll_request <= 1'b1;
            `MPCS_CMD_ENERGY_SCAN: begin
              scan_arg <= cmd_arg[2:0];
              scan_channel <= 5'h0;
              scan_peak <= 8'h0;
              scan_active <= 1'b1;
            end
            default: begin
            end
          endcase
          if (cmd_code != `MPCS_CMD_NAME_LOOKUP && cmd_code != `MPCS_CMD_ENERGY_SCAN) begin
            reply_ok <= 1'b1;
          end
        end
      end else if (cmd_valid) begin
        reply_error <= 1'b1;
      end
      // Name lookup result
      if (state == ST_LOOKUP) begin
        if (name_match_valid) begin
          dest_addr_upper <= name_match_addr[63:32];
          dest_addr_lower <= name_match_addr[31:0];
          reply_ok <= 1'b1;
          exit_command_mode <= 1'b1;
        end else if (lookup_done) begin
          reply_error <= 1'b1;
        end
      end
      // Energy scan: peak per channel, then CR
      if (state == ST_SCAN) begin
        if (dwell_done) begin
          scan_out_data <= (scan_energy > scan_peak) ? scan_energy : scan_peak;
          scan_out_valid <= 1'b1;
          scan_peak <= 8'h0;
          scan_channel <= scan_channel + 5'h1;
        end else if (dwell_busy && scan_energy > scan_peak) begin
          scan_peak <= scan_energy;
        end
      end
      if (state == ST_SCAN_CR) begin
        scan_out_valid <= 1'b1;
        scan_out_is_cr <= 1'b1;
        scan_out_data <= 8'h0D;
        scan_active <= 1'b0;
      end
      // Received packet handling
      if (sleep_event) begin
        rx_strength_read <= 7'h0;
      end else if (rx_packet) begin
        rx_strength_read <= (rx_strength > `MPCS_RSSI_MAX) ? `MPCS_RSSI_MAX : rx_strength;
      end
      if (rx_packet) begin
        rx_forward <= !(encrypt_enable && !rx_encrypted);
        rx_option_encrypted <= framed_host_mode && rx_encrypted;
        rx_long_indication <= mac_mode_setting != 2'h0 && framed_host_mode &&
          encrypt_enable && short_addr_set;
      end
      if (sleep_done && !associated) begin
        start_association <= 1'b1;
      end
    end
  end
endmodule // mpcs_command_core

// >>> hdl/mpcs_map.vh
// Constants for the modem parameter command block
`ifndef MPCS_MAP_VH
`define MPCS_MAP_VH
`define MPCS_CMD_NONE 4'h0
`define MPCS_CMD_WR_LINE7 4'h1
`define MPCS_CMD_WR_INPUT8 4'h2
`define MPCS_CMD_DISASSOC 4'h3
`define MPCS_CMD_WR_DEST_HI 4'h4
`define MPCS_CMD_WR_DEST_LO 4'h5
`define MPCS_CMD_NAME_LOOKUP 4'h6
`define MPCS_CMD_WR_SLEEP_PER 4'h7
`define MPCS_CMD_WR_ACK_CNT 4'h8
`define MPCS_CMD_WR_CCA_CNT 4'h9
`define MPCS_CMD_ENERGY_SCAN 4'hA
`define MPCS_CMD_WR_ENCRYPT 4'hB
`define MPCS_CMD_POLL 4'hC
`define MPCS_CMD_SOFT_RESET 4'hD
`define MPCS_LINE7_RESET 3'h1
`define MPCS_INPUT8_RESET 3'h0
`define MPCS_SLEEP_PER_RESET 16'h03E8
`define MPCS_SLEEP_PER_MAX 16'h68B0
`define MPCS_RSSI_MAX 7'h64
`define MPCS_SHORT_LIMIT 32'h0000FFFF
`define MPCS_ENC_PKT_MAX 7'h5F
`define MPCS_SCAN_ARG_MAX 3'h6
`define MPCS_CNT_MAX 16'hFFFF
`define MPCS_LOOKUP_TIMEOUT_US 200000
`define MPCS_SCAN_BASE_NS 15360000
`define MPCS_SLEEP_UNIT_NS 10000000
`define MPCS_CLK_NS 40
`define MPCS_NAME_MAX 5'h14
`endif

// >>> hdl/mpcs_sat_counter.v
// Saturating 16-bit event counter with clear
`timescale 1ns/1ps
`include "mpcs_map.vh"
module mpcs_sat_counter #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rst_b,
  input wire event_in,
  input wire clear,
  output reg [WIDTH-1:0] count
);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {WIDTH{1'b0}};
    end else if (event_in && clear) begin
      count <= {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (clear) begin
      count <= {WIDTH{1'b0}};
    end else if (event_in && count != {WIDTH{1'b1}}) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // mpcs_sat_counter

// >>> hdl/mpcs_timer.v
// Down-counting timer that pulses done when its load expires
`timescale 1ns/1ps
module mpcs_timer #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire rst_b,
  input wire load,
  input wire [WIDTH-1:0] load_value,
  input wire cancel,
  output reg busy,
  output reg done
);
  reg [WIDTH-1:0] remain;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      remain <= {WIDTH{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cancel) begin
        busy <= 1'b0;
      end else if (load) begin
        remain <= load_value;
        busy <= 1'b1;
      end else if (busy) begin
        if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // mpcs_timer

// >>> bench/mpcs_peer_model.sv
// Remote node model that answers name lookups
`timescale 1ns/1ps
module mpcs_peer_model #(
  parameter DELAY = 5,
  parameter [63:0] ADDR = 64'h1122334455667788
) (
  input wire clk,
  input wire rst_b,
  input wire lookup,
  input wire present,
  output reg name_match_valid,
  output wire [63:0] name_match_addr
);
  integer wait_cnt;
  // Idle lines show the inverse address
  assign name_match_addr = name_match_valid ? ADDR : ~ADDR;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 0;
      name_match_valid <= 1'b0;
    end else begin
      name_match_valid <= 1'b0;
      if (lookup && present) begin
        wait_cnt <= DELAY;
      end else if (wait_cnt > 0) begin
        wait_cnt <= wait_cnt - 1;
        name_match_valid <= (wait_cnt == 1);
      end
    end
  end
endmodule // mpcs_peer_model

// >>> bench/mpcs_core_asserts.sv
// Property checker for the modem parameter command core
`timescale 1ns/1ps
`include "mpcs_map.vh"
module mpcs_core_asserts (
  input wire clk,
  input wire rst_b,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [31:0] cmd_arg,
  input wire reply_error,
  input wire [2:0] line7_config,
  input wire [2:0] input8_config,
  input wire [31:0] dest_addr_upper,
  input wire [31:0] dest_addr_lower,
  input wire encrypt_enable,
  input wire [15:0] ack_fail_counter,
  input wire [15:0] cca_fail_counter,
  input wire [6:0] rx_strength_read,
  input wire drop_association,
  input wire start_association,
  input wire rx_packet,
  input wire rx_encrypted,
  input wire sleep_event,
  input wire rx_forward,
  input wire tx_short_addressing,
  input wire tx_broadcast,
  input wire tx_source_long,
  input wire [6:0] tx_max_packet,
  input wire ack_retries_out,
  input wire cca_withheld
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_line7_legal: assert property (line7_config != 3'h2 && line7_config <= 3'h5)
    else $error("line seven setting illegal");
  a_input8_legal: assert property (input8_config == 3'h0 || input8_config == 3'h3)
    else $error("input eight setting illegal");
  a_line7_reject: assert property (cmd_valid && cmd_code == `MPCS_CMD_WR_LINE7
    && cmd_arg == 32'h2 |=> reply_error && $stable(line7_config)) else $error("value 2 kept");
  a_rejoin_after_drop: assert property (drop_association |=> start_association)
    else $error("no new association after drop");
  a_strength_range: assert property (rx_strength_read <= `MPCS_RSSI_MAX)
    else $error("strength above limit");
  a_strength_sleep: assert property (sleep_event |=> rx_strength_read == 7'h0)
    else $error("strength not cleared by sleep");
  a_short_addr: assert property (tx_short_addressing == (dest_addr_upper == 32'h0
    && dest_addr_lower < `MPCS_SHORT_LIMIT)) else $error("short addressing wrong");
  a_broadcast_addr: assert property (tx_broadcast == ({dest_addr_upper,
    dest_addr_lower} == 64'h000000000000FFFF)) else $error("broadcast wrong");
  a_ack_count: assert property (ack_retries_out && !cmd_valid && !$past(cmd_valid)
    && ack_fail_counter != `MPCS_CNT_MAX |=> ack_fail_counter == $past(ack_fail_counter)
    + 16'h1) else $error("ack counter missed event");
  a_ack_saturate: assert property (ack_fail_counter == 16'hFFFF && !cmd_valid
    && !$past(cmd_valid) |=> ack_fail_counter == 16'hFFFF) else $error("ack wrapped");
  a_cca_count: assert property (cca_withheld && !cmd_valid && !$past(cmd_valid)
    && cca_fail_counter != `MPCS_CNT_MAX |=> cca_fail_counter == $past(cca_fail_counter)
    + 16'h1) else $error("cca counter missed event");
  a_enc_source: assert property (encrypt_enable |-> tx_source_long
    && tx_max_packet == `MPCS_ENC_PKT_MAX) else $error("encrypted tx limits wrong");
  a_plain_drop: assert property (rx_packet && encrypt_enable && !rx_encrypted
    |=> !rx_forward ##1 !rx_forward) else $error("plain packet forwarded");
endmodule // mpcs_core_asserts
bind mpcs_command_core mpcs_core_asserts mpcs_core_asserts_inst (.*);

// >>> bench/tb_mpcs_command_core.sv
// Self-checking bench for the modem parameter command core
`timescale 1ns/1ps
`include "mpcs_map.vh"
module tb_mpcs_command_core;
  localparam LK = 20, SB = 4, SU = 3;
  localparam [63:0] PA = 64'h1122334455667788;
  reg clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, end_device = 1'b0, cyclic_sleep_mode = 1'b0;
  reg [3:0] cmd_code = 4'h0;
  reg [31:0] cmd_arg = 32'h0;
  reg [4:0] name_len = 5'h5;
  reg associated = 1'b0, assoc_failed = 1'b0, rx_packet = 1'b0, rx_encrypted = 1'b0;
  reg sleep_event = 1'b0, framed_host_mode = 1'b1, ack_retries_out = 1'b0, cca_withheld = 1'b0;
  reg lookup = 1'b0, present = 1'b1, x, f;
  reg [6:0] rx_strength = 7'h0;
  reg [7:0] scan_energy = 8'h2A, peer_channel = 8'h0C, channel_number = 8'h0C;
  reg [15:0] peer_network = 16'h1234, network_identifier = 16'h1234;
  reg [15:0] source_short_addr = 16'h0001;
  reg [1:0] mac_mode_setting = 2'h1;
  reg [63:0] peer_dest = 64'h0;
  wire reply_ok, reply_error, exit_command_mode, encrypt_enable, drop_association;
  wire start_association, poll_request, unassoc_sleeping, name_match_valid, rx_forward;
  wire rx_option_encrypted, rx_long_indication, peer_match, tx_short_addressing, tx_broadcast;
  wire tx_source_long, scan_active, scan_out_valid, scan_out_is_cr, soft_reset_pulse;
  wire [2:0] line7_config, input8_config;
  wire [31:0] dest_addr_upper, dest_addr_lower;
  wire [15:0] unassoc_sleep_period, ack_fail_counter, cca_fail_counter;
  wire [6:0] rx_strength_read, tx_max_packet;
  wire [63:0] name_match_addr;
  wire [4:0] scan_channel;
  wire [7:0] scan_out_data;
  integer err_total = 0, n_checks = 0, cyc = 0, i, n, k, g, t, nd = 0, ns = 0, np = 0;
  always #20 clk = ~clk;
  mpcs_command_core #(.LOOKUP_CYCLES(LK), .SCAN_BASE_CYCLES(SB), .SLEEP_UNIT_CYCLES(SU))
    mpcs_command_core_inst (.*);
  mpcs_peer_model #(.DELAY(5), .ADDR(PA)) mpcs_peer_model_inst (.clk(clk), .rst_b(rst_b),
    .lookup(lookup), .present(present), .name_match_valid(name_match_valid),
    .name_match_addr(name_match_addr));
  always @(negedge clk) begin
    nd = nd + drop_association;
    ns = ns + start_association;
    np = np + poll_request;
  end
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task cmd(input [3:0] c, input [31:0] a, input ok);
    begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_arg = a;
      @(negedge clk);
      cmd_valid = 1'b0;
      chk(reply_ok, ok);
      chk(reply_error, !ok);
    end
  endtask
  task look(input [4:0] len, input pres);
    begin
      name_len = len;
      present = pres;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = `MPCS_CMD_NAME_LOOKUP;
      lookup = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      lookup = 1'b0;
      n = 0;
      while (reply_ok !== 1'b1 && reply_error !== 1'b1 && n < 60) begin
        @(negedge clk);
        n = n + 1;
      end
      x = exit_command_mode;
    end
  endtask
  task rxp(input enc, input [6:0] s);
    begin
      @(negedge clk);
      rx_packet = 1'b1;
      rx_encrypted = enc;
      rx_strength = s;
      @(negedge clk);
      rx_packet = 1'b0;
      f = rx_forward;
      @(negedge clk);
      f = f | rx_forward;
    end
  endtask
  task t_defaults;
    begin
      chk(line7_config, 3'h1);
      chk(input8_config, 3'h0);
      chk({dest_addr_upper, dest_addr_lower}, 64'h0);
      chk(unassoc_sleep_period, 16'h03E8);
      chk(rx_strength_read, 7'h0);
      $display("defaults done");
    end
  endtask
  task t_lines;
    reg [2:0] e;
    begin
      e = 3'h1;
      for (i = 0; i < 7; i = i + 1) begin
        cmd(`MPCS_CMD_WR_LINE7, i, i != 2 && i != 6);
        if (i != 2 && i != 6) e = i;
        chk(line7_config, e);
        cmd(`MPCS_CMD_WR_INPUT8, i, i == 0 || i == 3);
        chk(input8_config, (i >= 3) ? 3'h3 : 3'h0);
      end
      $display("lines done");
    end
  endtask
  task t_lookup;
    begin
      look(5'h5, 1'b1);
      chk(reply_ok, 1'b1);
      chk(x, 1'b1);
      chk({dest_addr_upper, dest_addr_lower}, PA);
      look(5'h5, 1'b0);
      chk(reply_error, 1'b1);
      chk(n >= LK && n <= LK + 3, 1'b1);
      look(5'h0, 1'b0);
      chk(reply_error && n <= 2, 1'b1);
      look(5'h15, 1'b0);
      chk(reply_error && n <= 2, 1'b1);
      $display("lookup done");
    end
  endtask
  task t_dest;
    begin
      cmd(`MPCS_CMD_WR_DEST_HI, 32'h0, 1'b1);
      cmd(`MPCS_CMD_WR_DEST_LO, 32'hFFFE, 1'b1);
      chk({tx_short_addressing, tx_broadcast}, 2'h2);
      cmd(`MPCS_CMD_WR_DEST_LO, 32'hFFFF, 1'b1);
      chk({tx_short_addressing, tx_broadcast}, 2'h1);
      cmd(`MPCS_CMD_WR_DEST_HI, 32'h1, 1'b1);
      chk({dest_addr_upper, dest_addr_lower}, 64'h1_0000FFFF);
      chk({tx_short_addressing, tx_broadcast}, 2'h0);
      peer_dest = 64'h1_0000FFFF;
      #1 chk(peer_match, 1'b1);
      peer_channel = 8'h0D;
      #1 chk(peer_match, 1'b0);
      $display("dest done");
    end
  endtask
  task t_counters;
    begin
      ack_retries_out = 1'b1;
      cca_withheld = 1'b1;
      repeat (3) @(negedge clk);
      cca_withheld = 1'b0;
      repeat (65540) @(negedge clk);
      ack_retries_out = 1'b0;
      @(negedge clk);
      chk(ack_fail_counter, 16'hFFFF);
      chk(cca_fail_counter, 16'h3);
      cmd(`MPCS_CMD_WR_ACK_CNT, 32'h5, 1'b0);
      chk(ack_fail_counter, 16'hFFFF);
      cmd(`MPCS_CMD_WR_ACK_CNT, 32'h0, 1'b1);
      cmd(`MPCS_CMD_WR_CCA_CNT, 32'h0, 1'b1);
      chk({ack_fail_counter, cca_fail_counter}, 32'h0);
      $display("counters done");
    end
  endtask
  task t_scan;
    begin
      cmd(`MPCS_CMD_ENERGY_SCAN, 32'h7, 1'b0);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = `MPCS_CMD_ENERGY_SCAN;
      cmd_arg = 32'h1;
      n = 0;
      k = 0;
      for (i = 0; i < 200; i = i + 1) begin
        @(negedge clk);
        cmd_valid = 1'b0;
        if (scan_out_valid === 1'b1 && scan_out_is_cr !== 1'b1) begin
          n = n + 1;
          if (n == 2) t = i;
          if (n == 3) g = i - t;
          chk(scan_out_data, 8'h2A);
        end
        if (scan_out_is_cr === 1'b1) begin
          k = k + 1;
          chk(scan_out_data, 8'h0D);
        end
      end
      chk({scan_active, scan_channel}, 6'h10);
      chk(n, 16);
      chk(k, 1);
      chk(g, SB << 1);
      $display("scan done");
    end
  endtask
  task t_crypto;
    begin
      cmd(`MPCS_CMD_WR_ENCRYPT, 32'h2, 1'b0);
      cmd(`MPCS_CMD_WR_ENCRYPT, 32'h1, 1'b1);
      chk({encrypt_enable, tx_source_long, tx_max_packet}, {2'h3, 7'h5F});
      rxp(1'b0, 7'h10);
      chk(f, 1'b0);
      rxp(1'b1, 7'h58);
      chk({f, rx_option_encrypted, rx_long_indication}, 3'h7);
      chk(rx_strength_read, 7'h58);
      cmd(`MPCS_CMD_WR_ENCRYPT, 32'h0, 1'b1);
      chk(tx_max_packet, 7'h7F);
      rxp(1'b1, 7'h70);
      chk(rx_strength_read, 7'h64);
      @(negedge clk);
      sleep_event = 1'b1;
      @(negedge clk);
      sleep_event = 1'b0;
      chk(rx_strength_read, 7'h0);
      $display("crypto done");
    end
  endtask
  task t_assoc;
    begin
      end_device = 1'b1;
      cyclic_sleep_mode = 1'b1;
      cmd(`MPCS_CMD_DISASSOC, 32'h0, 1'b1);
      repeat (2) @(negedge clk);
      chk({nd, ns}, {32'd1, 32'd1});
      cmd(`MPCS_CMD_POLL, 32'h0, 1'b1);
      repeat (2) @(negedge clk);
      chk(np, 1);
      cmd(`MPCS_CMD_WR_SLEEP_PER, 32'h0, 1'b0);
      cmd(`MPCS_CMD_WR_SLEEP_PER, 32'h68B1, 1'b0);
      cmd(`MPCS_CMD_WR_SLEEP_PER, 32'h68B0, 1'b1);
      chk(unassoc_sleep_period, 16'h68B0);
      cmd(`MPCS_CMD_WR_SLEEP_PER, 32'h2, 1'b1);
      @(negedge clk);
      assoc_failed = 1'b1;
      @(negedge clk);
      assoc_failed = 1'b0;
      n = (unassoc_sleeping === 1'b1);
      for (i = 0; i < 40; i = i + 1) begin
        @(negedge clk);
        n = n + (unassoc_sleeping === 1'b1);
      end
      chk(n >= 2 * SU && n <= 2 * SU + 1, 1'b1);
      chk(ns, 2);
      $display("assoc done");
    end
  endtask
  task t_reset;
    begin
      cmd(`MPCS_CMD_WR_LINE7, 32'h4, 1'b1);
      cmd(`MPCS_CMD_SOFT_RESET, 32'h0, 1'b1);
      @(negedge clk);
      chk(soft_reset_pulse, 1'b1);
      @(negedge clk);
      chk({line7_config, unassoc_sleep_period}, {3'h1, 16'h03E8});
      $display("reset done");
    end
  endtask
  task conclude;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total = err_total + 1;
      conclude;
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    t_defaults;
    t_lines;
    t_lookup;
    t_dest;
    t_counters;
    t_scan;
    t_crypto;
    t_assoc;
    t_reset;
    conclude;
  end
endmodule // tb_mpcs_command_core
